/* rtl/gpf_core.sv */
// gpf_core: input side of a 32-line port: sync, filters, events, lock.
// assumes a one-cycle strobe register port and an asynchronous slow clock
// pin; peripherals and the lock requesters run on core_clk.
`timescale 1ns/10ps
module gpf_core (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      reset_n,
   // register port
   input  wire logic [gpf_pkg::AW-1:0]    bus_addr,
   input  wire logic [31:0]               bus_wdata,
   input  wire logic                      bus_wr,
   input  wire logic                      bus_rd,
   output logic      [31:0]               bus_rdata,
   // pins and system inputs
   input  wire logic [31:0]               pin_in,
   input  wire logic                      slow_clk,
   input  wire logic                      ctrl_clk_en,
   input  wire logic [31:0]               lock_req,
   // towards pads and peripherals
   output logic [31:0]                    periph_in,
   output logic [31:0]                    ctrl_sel,
   output logic [31:0]                    out_en,
   output logic [31:0]                    out_data,
   output logic [31:0]                    multidrive,
   output logic [31:0]                    pullup_off,
   output logic [31:0]                    psel_one,
   output logic [31:0]                    psel_two,
   output logic                           irq
);
   import gpf_pkg::*;

   typedef struct packed {
      logic [31:0]      ps1;
      logic [31:0]      ps2;
      logic [31:0]      ps3;
      logic [31:0]      pin;
      logic             sc1;
      logic             sc2;
      logic             sc3;
      logic [DIV_W-1:0] dcnt;
      logic [DIV_W-1:0] sdiv;
      logic [31:0]      smp;
      logic [31:0]      flvl;
      logic [31:0]      pdsr;
      logic [31:0]      prev;
      logic [31:0]      cfg;
      logic [31:0]      oe;
      logic [31:0]      odsr;
      logic [31:0]      owsr;
      logic [31:0]      ifsr;
      logic [31:0]      sck;
      logic [31:0]      imr;
      logic [31:0]      isr;
      logic [31:0]      xm;
      logic [31:0]      lvl;
      logic [31:0]      pol;
      logic [31:0]      md;
      logic [31:0]      pu;
      logic [31:0]      ps_a;
      logic [31:0]      ps_b;
      logic [31:0]      lock;
      logic             protect_enable_bit;
      logic             protect_violation_flag;
      logic [AW-1:0]    vsrc;
      logic [31:0]      rdata;
      logic             irq;
   } gpf_state_t;

   gpf_state_t q;
   gpf_state_t d;

   logic        wr_ok;
   logic        half_tick;
   logic        slow_rise;
   logic [31:0] wl;
   logic [31:0] level;
   logic [31:0] agree;
   logic [31:0] edge_v;
   logic [31:0] ev;

   // set bits on one strobe, clear on the other, else hold
   function automatic logic [31:0] gpf_setclr(input logic [31:0] v,
                                              input logic        s,
                                              input logic        c,
                                              input logic [31:0] w);
      if (s) begin
         return v | w;
      end else if (c) begin
         return v & ~w;
      end
      return v;
   endfunction : gpf_setclr

   // registers that the protection scheme guards
   function automatic logic gpf_prot(input logic [AW-1:0] a);
      case (a)
         A_CFG_EN, A_CFG_DIS, A_OE_EN, A_OE_DIS, A_FLT_EN, A_FLT_DIS,
         A_MD_EN, A_MD_DIS, A_PU_DIS, A_PU_EN, A_PSEL1, A_PSEL2,
         A_OW_EN, A_OW_DIS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : gpf_prot

   // writes that survive protection; locked lines masked out
   assign wr_ok = bus_wr && !(q.protect_enable_bit && gpf_prot(bus_addr));
   assign wl    = bus_wdata & ~q.lock;

   // slow clock edge from the back of its synchroniser
   assign slow_rise = q.sc2 && !q.sc3;
   assign half_tick = slow_rise && (q.dcnt == q.sdiv);

   // debounce: two successive half-period samples must agree
   assign agree = ~(q.pin ^ q.smp);
   // filtered or raw level per line
   assign level = (q.ifsr & q.flvl) | (~q.ifsr & q.pin);

   // change detection between two successive pin samples
   assign edge_v = q.pdsr ^ q.prev;
   always_comb begin
      for (int i = 0; i < LINES; i++) begin
         if (!q.xm[i]) begin
            ev[i] = edge_v[i];
         end else if (q.lvl[i]) begin
            ev[i] = q.pol[i] ? q.pdsr[i] : !q.pdsr[i];
         end else begin
            ev[i] = edge_v[i] && (q.pol[i] ? q.pdsr[i] : !q.pdsr[i]);
         end
      end
      if (!ctrl_clk_en) begin
         ev = '0;
      end
   end

   // next state
   always_comb begin
      d = q;
      // three-stage pin sync, change taken when stages two and three agree
      d.ps1 = pin_in;
      d.ps2 = q.ps1;
      d.ps3 = q.ps2;
      d.pin = (q.ps2 == q.ps3) ? q.ps3 : q.pin;
      d.sc1 = slow_clk;
      d.sc2 = q.sc1;
      d.sc3 = q.sc2;
      // divided slow clock: half period every div+1 slow edges
      if (slow_rise) begin
         d.dcnt = half_tick ? '0 : q.dcnt + 1'b1;
      end
      // filters run only while the controller clock runs
      if (ctrl_clk_en) begin
         if (half_tick) begin
            d.smp  = q.pin;
            d.flvl = (q.sck & ((agree & q.pin) | (~agree & q.flvl)))
                   | (~q.sck & q.pin);
         end else begin
            d.flvl = (q.sck & q.flvl) | (~q.sck & q.pin);
         end
         d.pdsr = level;
         d.prev = q.pdsr;
      end
      // status: a new event wins over the read clear
      if (bus_rd && bus_addr == A_IRQ_ST) begin
         d.isr = '0;
      end
      d.isr = d.isr | ev;
      d.irq = |(q.isr & q.imr);
      // lock is sticky until reset
      d.lock = q.lock | lock_req;
      // protection violation logging
      if (bus_wr && q.protect_enable_bit && gpf_prot(bus_addr)) begin
         d.protect_violation_flag = 1'b1;
         d.vsrc = bus_addr;
      end
      // register writes
      if (wr_ok) begin
         case (bus_addr)
            A_CFG_EN:   d.cfg  = q.cfg | wl;
            A_CFG_DIS:  d.cfg  = q.cfg & ~wl;
            A_MD_EN:    d.md   = q.md | wl;
            A_MD_DIS:   d.md   = q.md & ~wl;
            A_PU_DIS:   d.pu   = q.pu | wl;
            A_PU_EN:    d.pu   = q.pu & ~wl;
            A_PSEL1:    d.ps_a = (q.ps_a & q.lock) | wl;
            A_PSEL2:    d.ps_b = (q.ps_b & q.lock) | wl;
            A_OE_EN:    d.oe   = gpf_setclr(q.oe, 1'b1, 1'b0, bus_wdata);
            A_OE_DIS:   d.oe   = gpf_setclr(q.oe, 1'b0, 1'b1, bus_wdata);
            A_FLT_EN:   d.ifsr = gpf_setclr(q.ifsr, 1'b1, 1'b0, bus_wdata);
            A_FLT_DIS:  d.ifsr = gpf_setclr(q.ifsr, 1'b0, 1'b1, bus_wdata);
            A_SET_OUT:  d.odsr = q.odsr | bus_wdata;
            A_CLR_OUT:  d.odsr = q.odsr & ~bus_wdata;
            A_OUT_ST:   d.odsr = (q.odsr & ~q.owsr) | (bus_wdata & q.owsr);
            A_OW_EN:    d.owsr = q.owsr | bus_wdata;
            A_OW_DIS:   d.owsr = q.owsr & ~bus_wdata;
            A_IRQ_EN:   d.imr  = gpf_setclr(q.imr, 1'b1, 1'b0, bus_wdata);
            A_IRQ_DIS:  d.imr  = gpf_setclr(q.imr, 1'b0, 1'b1, bus_wdata);
            A_SCK_DIS:  d.sck  = gpf_setclr(q.sck, 1'b1, 1'b0, bus_wdata);
            A_SCK_EN:   d.sck  = gpf_setclr(q.sck, 1'b0, 1'b1, bus_wdata);
            A_SDIV:     d.sdiv = bus_wdata[DIV_W-1:0];
            A_XM_EN:    d.xm   = gpf_setclr(q.xm, 1'b1, 1'b0, bus_wdata);
            A_XM_DIS:   d.xm   = gpf_setclr(q.xm, 1'b0, 1'b1, bus_wdata);
            A_EDGE_SEL: d.lvl  = gpf_setclr(q.lvl, 1'b0, 1'b1, bus_wdata);
            A_LVL_SEL:  d.lvl  = gpf_setclr(q.lvl, 1'b1, 1'b0, bus_wdata);
            A_FALL_SEL: d.pol  = gpf_setclr(q.pol, 1'b0, 1'b1, bus_wdata);
            A_RISE_SEL: d.pol  = gpf_setclr(q.pol, 1'b1, 1'b0, bus_wdata);
            A_PROT_MODE: begin
               if (bus_wdata[31:KEY_LSB] == PROT_KEY) begin
                  d.protect_enable_bit = bus_wdata[PROT_EN_BIT];
                  d.protect_violation_flag = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // read data, valid the cycle after the strobe only
      d.rdata = '0;
      if (bus_rd) begin
         case (bus_addr)
            A_CFG_ST:    d.rdata = q.cfg;
            A_OE_ST:     d.rdata = q.oe;
            A_FLT_ST:    d.rdata = q.ifsr;
            A_OUT_ST:    d.rdata = q.odsr;
            A_PIN_ST:    d.rdata = q.pdsr;
            A_IRQ_MASK:  d.rdata = q.imr;
            A_IRQ_ST:    d.rdata = q.isr;
            A_MD_ST:     d.rdata = q.md;
            A_PU_ST:     d.rdata = q.pu;
            A_PSEL1:     d.rdata = q.ps_a;
            A_PSEL2:     d.rdata = q.ps_b;
            A_SCK_ST:    d.rdata = q.sck;
            A_SDIV:      d.rdata = {{(32-DIV_W){1'b0}}, q.sdiv};
            A_OW_ST:     d.rdata = q.owsr;
            A_XM_ST:     d.rdata = q.xm;
            A_EL_ST:     d.rdata = q.lvl;
            A_POL_ST:    d.rdata = q.pol;
            A_LOCK_ST:   d.rdata = q.lock;
            A_PROT_MODE: d.rdata = {31'h0000_0000, q.protect_enable_bit};
            A_PROT_ST:   d.rdata = {16'h0000, q.vsrc, 7'h00, q.protect_violation_flag};
            default:     d.rdata = '0;
         endcase
      end
   end

   // state register, synchronous reset
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         q      <= '0;
         q.cfg  <= CFG_RST;
         q.odsr <= ZERO_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from state
   assign bus_rdata  = q.rdata;
   assign periph_in  = q.pin;
   assign ctrl_sel   = q.cfg;
   assign out_en     = q.oe;
   assign out_data   = q.odsr;
   assign multidrive = q.md;
   assign pullup_off = q.pu;
   assign psel_one   = q.ps_a;
   assign psel_two   = q.ps_b;
   assign irq        = q.irq;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   chk_masked_odsr: assert property (
      wr_ok && bus_addr == A_OUT_ST |=>
      q.odsr == (($past(q.odsr) & ~$past(q.owsr)) | ($past(bus_wdata) & $past(q.owsr))))
      else $error("masked output write wrong");
   chk_pin_freeze: assert property (
      !ctrl_clk_en [*2] |-> $stable(q.pdsr))
      else $error("pin level moved with clock off");
   chk_filter_sel: assert property (
      wr_ok && bus_addr == A_SCK_DIS |=> (q.sck & $past(bus_wdata)) == $past(bus_wdata))
      else $error("filter clock select not set");
   chk_div_count: assert property (
      slow_rise && q.dcnt != q.sdiv |=> q.dcnt == $past(q.dcnt) + 1'b1)
      else $error("slow divider did not count");
   chk_unfilt_path: assert property (
      q.ps2 == q.ps3 |=> periph_in == $past(q.ps3))
      else $error("peripheral input not raw level");
   chk_mask_set: assert property (
      wr_ok && bus_addr == A_IRQ_EN |=> (q.imr & $past(bus_wdata)) == $past(bus_wdata))
      else $error("irq mask bit not set");
   chk_any_edge: assert property (
      ctrl_clk_en && |(edge_v & ~q.xm) |=> |(q.isr & $past(edge_v & ~q.xm)))
      else $error("edge not captured");
   chk_irq_or: assert property (
      |(q.isr & q.imr) |=> irq)
      else $error("irq not raised");
   chk_lock_sticky: assert property (
      1'b1 |=> (q.lock & $past(q.lock)) == $past(q.lock))
      else $error("lock bit dropped");
   chk_lock_discard: assert property (
      bus_wr && bus_addr == A_CFG_DIS |=> (q.cfg & $past(q.lock)) == ($past(q.cfg) & $past(q.lock)))
      else $error("locked line changed");
   chk_prot_flag: assert property (
      bus_wr && q.protect_enable_bit && gpf_prot(bus_addr) |=> q.protect_violation_flag && q.vsrc == $past(bus_addr))
      else $error("violation not logged");
   cov_isr_read: cover property (bus_rd && bus_addr == A_IRQ_ST && |q.isr);
   cov_debounce: cover property (half_tick && |(q.sck & q.ifsr));
   cov_key_clear: cover property (q.protect_violation_flag ##1 !q.protect_violation_flag);
endmodule : gpf_core

/* rtl/gpf_pkg.sv */
// gpf_pkg: constants for the 32-line input filter, event and lock block.
// assumes a simple strobe register port with byte addresses on 8 bits.
package gpf_pkg;
   localparam int          LINES       = 32;
   localparam int          AW          = 8;
   localparam int          DIV_W       = 14;
   localparam logic [7:0]  A_CFG_EN    = 8'h00;
   localparam logic [7:0]  A_CFG_DIS   = 8'h04;
   localparam logic [7:0]  A_CFG_ST    = 8'h08;
   localparam logic [7:0]  A_OE_EN     = 8'h10;
   localparam logic [7:0]  A_OE_DIS    = 8'h14;
   localparam logic [7:0]  A_OE_ST     = 8'h18;
   localparam logic [7:0]  A_FLT_EN    = 8'h20;
   localparam logic [7:0]  A_FLT_DIS   = 8'h24;
   localparam logic [7:0]  A_FLT_ST    = 8'h28;
   localparam logic [7:0]  A_SET_OUT   = 8'h30;
   localparam logic [7:0]  A_CLR_OUT   = 8'h34;
   localparam logic [7:0]  A_OUT_ST    = 8'h38;
   localparam logic [7:0]  A_PIN_ST    = 8'h3C;
   localparam logic [7:0]  A_IRQ_EN    = 8'h40;
   localparam logic [7:0]  A_IRQ_DIS   = 8'h44;
   localparam logic [7:0]  A_IRQ_MASK  = 8'h48;
   localparam logic [7:0]  A_IRQ_ST    = 8'h4C;
   localparam logic [7:0]  A_MD_EN     = 8'h50;
   localparam logic [7:0]  A_MD_DIS    = 8'h54;
   localparam logic [7:0]  A_MD_ST     = 8'h58;
   localparam logic [7:0]  A_PU_DIS    = 8'h60;
   localparam logic [7:0]  A_PU_EN     = 8'h64;
   localparam logic [7:0]  A_PU_ST     = 8'h68;
   localparam logic [7:0]  A_PSEL1     = 8'h70;
   localparam logic [7:0]  A_PSEL2     = 8'h74;
   localparam logic [7:0]  A_SCK_DIS   = 8'h80;
   localparam logic [7:0]  A_SCK_EN    = 8'h84;
   localparam logic [7:0]  A_SCK_ST    = 8'h88;
   localparam logic [7:0]  A_SDIV      = 8'h8C;
   localparam logic [7:0]  A_OW_EN     = 8'hA0;
   localparam logic [7:0]  A_OW_DIS    = 8'hA4;
   localparam logic [7:0]  A_OW_ST     = 8'hA8;
   localparam logic [7:0]  A_XM_EN     = 8'hB0;
   localparam logic [7:0]  A_XM_DIS    = 8'hB4;
   localparam logic [7:0]  A_XM_ST     = 8'hB8;
   localparam logic [7:0]  A_EDGE_SEL  = 8'hC0;
   localparam logic [7:0]  A_LVL_SEL   = 8'hC4;
   localparam logic [7:0]  A_EL_ST     = 8'hC8;
   localparam logic [7:0]  A_FALL_SEL  = 8'hD0;
   localparam logic [7:0]  A_RISE_SEL  = 8'hD4;
   localparam logic [7:0]  A_POL_ST    = 8'hD8;
   localparam logic [7:0]  A_LOCK_ST   = 8'hE0;
   localparam logic [7:0]  A_PROT_MODE = 8'hE4;
   localparam logic [7:0]  A_PROT_ST   = 8'hE8;
   // protection mode: enable in bit 0, key in bits 31:8
   localparam int          PROT_EN_BIT = 0;
   localparam int          KEY_LSB     = 8;
   // key value is arbitrary
   localparam logic [23:0] PROT_KEY    = 24'hA5_C3E1;
   // protection status: flag in bit 0, source address in bits 15:8
   localparam int          VSRC_LSB    = 8;
   localparam logic [31:0] CFG_RST     = 32'hFFFF_FFFF;
   localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
endpackage : gpf_pkg

/* verification/gpf_core_tb.sv */
// gpf_core_tb: self-checking bench for the input filter, event and lock block.
// assumes gpf_pkg and gpf_core are compiled first; everything runs on core_clk.
`timescale 1ns/10ps
module gpf_core_tb;
   import gpf_pkg::*;

   // one table row: a write, then a read with its expected word
   typedef struct packed {
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [7:0]  ra;
      logic [31:0] exp;
   } gpf_row_t;

   localparam int       NROWS = 29;
   localparam gpf_row_t ROWS [0:NROWS-1] = '{
      '{A_FLT_EN,   32'h0000_0F0F, A_FLT_ST,   32'h0000_0F0F},
      '{A_FLT_DIS,  32'h0000_000F, A_FLT_ST,   32'h0000_0F00},
      '{A_SCK_DIS,  32'h0000_00FF, A_SCK_ST,   32'h0000_00FF},
      '{A_SCK_EN,   32'h0000_000F, A_SCK_ST,   32'h0000_00F0},
      '{A_IRQ_EN,   32'hFFFF_FFFF, A_IRQ_MASK, 32'hFFFF_FFFF},
      '{A_IRQ_DIS,  32'hFFFF_0000, A_IRQ_MASK, 32'h0000_FFFF},
      '{A_XM_EN,    32'h0000_00FF, A_XM_ST,    32'h0000_00FF},
      '{A_XM_DIS,   32'h0000_00F0, A_XM_ST,    32'h0000_000F},
      '{A_LVL_SEL,  32'h0000_0038, A_EL_ST,    32'h0000_0038},
      '{A_EDGE_SEL, 32'h0000_0008, A_EL_ST,    32'h0000_0030},
      '{A_RISE_SEL, 32'h0000_00B5, A_POL_ST,   32'h0000_00B5},
      '{A_FALL_SEL, 32'h0000_0001, A_POL_ST,   32'h0000_00B4},
      '{A_OW_EN,    32'h0000_000F, A_OW_ST,    32'h0000_000F},
      '{A_OUT_ST,   32'h0000_00FF, A_OUT_ST,   32'h0000_000F},
      '{A_SET_OUT,  32'h0000_0100, A_OUT_ST,   32'h0000_010F},
      '{A_CLR_OUT,  32'h0000_0001, A_OUT_ST,   32'h0000_010E},
      '{A_SDIV,     32'h0000_0003, A_SDIV,     32'h0000_0003},
      '{8'hFC,      32'hFFFF_FFFF, 8'hFC,      32'h0000_0000},
      '{A_MD_EN,    32'h0000_000F, A_MD_ST,    32'h0000_000F},
      '{A_MD_DIS,   32'h0000_0003, A_MD_ST,    32'h0000_000C},
      '{A_CFG_DIS,  32'hFFFF_0000, A_CFG_ST,   32'h0000_FFFF},
      '{A_CFG_EN,   32'h0001_0000, A_CFG_ST,   32'h0001_FFFF},
      '{A_PU_DIS,   32'h0000_00F0, A_PU_ST,    32'h0000_00F0},
      '{A_PU_EN,    32'h0000_0030, A_PU_ST,    32'h0000_00C0},
      '{A_PSEL1,    32'h0000_0005, A_PSEL1,    32'h0000_0005},
      '{A_PSEL2,    32'h0000_000A, A_PSEL2,    32'h0000_000A},
      '{A_OE_EN,    32'h0000_00FF, A_OE_ST,    32'h0000_00FF},
      '{A_OE_DIS,   32'h0000_000F, A_OE_ST,    32'h0000_00F0},
      '{A_OW_DIS,   32'h0000_0003, A_OW_ST,    32'h0000_000C}
   };

   // design ports
   logic        core_clk;
   logic        reset_n;
   logic [7:0]  bus_addr;
   logic [31:0] bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [31:0] bus_rdata;
   logic [31:0] pin_in;
   logic        slow_clk = 1'b0;
   logic        ctrl_clk_en;
   logic [31:0] lock_req;
   logic [31:0] periph_in;
   logic [31:0] ctrl_sel;
   logic [31:0] out_en;
   logic [31:0] out_data;
   logic [31:0] multidrive;
   logic [31:0] pullup_off;
   logic [31:0] psel_one;
   logic [31:0] psel_two;
   logic        irq;
   // bench state
   int          mismatches;
   int          num_checks;
   logic [3:0]  slow_cnt = 4'h0;
   logic [31:0] rv;
   logic        seen;

   gpf_core i_dut (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .bus_addr   (bus_addr),
      .bus_wdata  (bus_wdata),
      .bus_wr     (bus_wr),
      .bus_rd     (bus_rd),
      .bus_rdata  (bus_rdata),
      .pin_in     (pin_in),
      .slow_clk   (slow_clk),
      .ctrl_clk_en(ctrl_clk_en),
      .lock_req   (lock_req),
      .periph_in  (periph_in),
      .ctrl_sel   (ctrl_sel),
      .out_en     (out_en),
      .out_data   (out_data),
      .multidrive (multidrive),
      .pullup_off (pullup_off),
      .psel_one   (psel_one),
      .psel_two   (psel_two),
      .irq        (irq)
   );

   // 125 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // slow clock: toggles every 10 core cycles, a 160 ns period
   always @(posedge core_clk) begin
      slow_cnt <= (slow_cnt == 4'h9) ? 4'h0 : slow_cnt + 4'h1;
      if (slow_cnt == 4'h9) slow_clk <= ~slow_clk;
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // verdict and end of run
   task automatic end_of_test();
      if (mismatches == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge core_clk);
      bus_wr    <= 1'b0;
      #1;
   endtask : wr

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge core_clk);
      bus_rd   <= 1'b0;
      #1;
      rv = bus_rdata;
      chk(rv, exp);
   endtask : rd

   // bounded wait for the interrupt line to reach a level
   task automatic wait_irq(input logic exp);
      int i;
      i = 0;
      #1;
      while (irq !== exp && i < 20) begin
         tick(1);
         i++;
      end
      chk({31'h0, irq}, {31'h0, exp});
      if (irq !== exp) end_of_test();
   endtask : wait_irq

   // quiet inputs, then reset held for 5 cycles
   task automatic do_reset();
      @(posedge core_clk);
      pin_in   <= '0;
      lock_req <= '0;
      reset_n  <= 1'b0;
      repeat (5) @(posedge core_clk);
      reset_n  <= 1'b1;
      tick(2);
   endtask : do_reset

   // main sequence
   initial begin
      reset_n = 1'b0; bus_addr = '0; bus_wdata = '0; bus_wr = 1'b0; bus_rd = 1'b0;
      pin_in = '0; ctrl_clk_en = 1'b1; lock_req = '0;
      mismatches = 0; num_checks = 0; seen = 1'b0;
      do_reset();
      chk(ctrl_sel, CFG_RST);
      chk({31'h0, irq}, 32'h0000_0000);
      for (int r = 0; r < NROWS; r++) begin
         wr(ROWS[r].wa, ROWS[r].wd);
         rd(ROWS[r].ra, ROWS[r].exp);
      end
      chk(out_data, 32'h0000_010E);
      // any edge counts, masked OR, read clears
      do_reset();
      wr(A_IRQ_EN, 32'h0000_0001);
      @(posedge core_clk) pin_in <= 32'h0000_0001;
      wait_irq(1'b1);
      rd(A_PIN_ST, 32'h0000_0001);
      rd(A_IRQ_ST, 32'h0000_0001);
      rd(A_IRQ_ST, 32'h0000_0000);
      wait_irq(1'b0);
      @(posedge core_clk) pin_in <= 32'h0000_0100;
      wait_irq(1'b1);
      tick(10);
      rd(A_IRQ_ST, 32'h0000_0101);
      wait_irq(1'b0);
      // level high on line 1, rising only on line 4
      do_reset();
      wr(A_XM_EN, 32'h0000_0012);
      wr(A_LVL_SEL, 32'h0000_0002);
      wr(A_RISE_SEL, 32'h0000_0012);
      @(posedge core_clk) pin_in <= 32'h0000_0012;
      tick(12);
      rd(A_IRQ_ST, 32'h0000_0012);
      @(posedge core_clk) pin_in <= 32'h0000_0002;
      tick(12);
      rd(A_IRQ_ST, 32'h0000_0002);
      // pin level frozen while the controller clock is off
      @(posedge core_clk) ctrl_clk_en <= 1'b0;
      pin_in <= '0;
      tick(12);
      rd(A_PIN_ST, 32'h0000_0002);
      @(posedge core_clk) ctrl_clk_en <= 1'b1;
      tick(12);
      rd(A_PIN_ST, 32'h0000_0000);
      // debounce on line 5: short pulse dropped, peripherals still see it
      do_reset();
      wr(A_FLT_EN, 32'h0000_0020);
      wr(A_SCK_DIS, 32'h0000_0020);
      for (int k = 0; k < 12; k++) begin
         @(posedge core_clk);
         pin_in <= (k < 3) ? 32'h0000_0020 : '0;
         #1;
         seen |= periph_in[5];
      end
      chk({31'h0, seen}, 32'h0000_0001);
      tick(60);
      rd(A_PIN_ST, 32'h0000_0000);
      @(posedge core_clk) pin_in <= 32'h0000_0020;
      tick(100);
      rd(A_PIN_ST, 32'h0000_0020);
      // lock on line 0 blocks config writes until reset
      do_reset();
      @(posedge core_clk) lock_req <= 32'h0000_0001;
      @(posedge core_clk) lock_req <= '0;
      tick(3);
      rd(A_LOCK_ST, 32'h0000_0001);
      wr(A_CFG_DIS, 32'hFFFF_FFFF);
      wr(A_MD_EN, 32'hFFFF_FFFF);
      wr(A_PSEL1, 32'hFFFF_FFFF);
      chk(ctrl_sel, 32'h0000_0001);
      chk(multidrive, 32'hFFFF_FFFE);
      chk(psel_one, 32'hFFFF_FFFE);
      wr(A_PU_DIS, 32'hFFFF_FFFF);
      wr(A_PSEL2, 32'hFFFF_FFFF);
      chk(pullup_off, 32'hFFFF_FFFE);
      chk(psel_two, 32'hFFFF_FFFE);
      rd(A_LOCK_ST, 32'h0000_0001);
      do_reset();
      rd(A_LOCK_ST, 32'h0000_0000);
      // protection: write dropped and logged, wrong key ignored, right key clears
      wr(A_PROT_MODE, {PROT_KEY, 8'h01});
      rd(A_PROT_MODE, 32'h0000_0001);
      wr(A_OE_EN, 32'hFFFF_FFFF);
      chk(out_en, 32'h0000_0000);
      rd(A_PROT_ST, {16'h0000, A_OE_EN, 8'h01});
      wr(A_PROT_MODE, 32'h0000_0000);
      rd(A_PROT_ST, {16'h0000, A_OE_EN, 8'h01});
      wr(A_PROT_MODE, {PROT_KEY, 8'h00});
      rd(A_PROT_ST, {16'h0000, A_OE_EN, 8'h00});
      chk({31'h0, rv[0]}, 32'h0000_0000);
      wr(A_OE_EN, 32'hFFFF_FFFF);
      chk(out_en, 32'hFFFF_FFFF);
      end_of_test();
   end
endmodule : gpf_core_tb
